//--- rtl/ckd_pkg.sv
// Constants for the dual oscillator clock control block.
// Assumes APB with 32-bit data and a single 10 MHz system clock.
package ckd_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] CKD_IDX_TB_CTRL  = 6'h3c;
    localparam logic [5:0] CKD_IDX_MASK_OPT = 6'h3d;
    localparam logic [5:0] CKD_IDX_MISC     = 6'h3e;
    localparam int         CKD_ADDR_W       = 8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CKD_MISC_STABLE  = 7;
    localparam int CKD_MISC_SEL_HI  = 3;
    localparam int CKD_MISC_SEL_LO  = 2;
    localparam int CKD_MISC_ENABLE  = 1;
    localparam int CKD_TB_SRC_BIT   = 7;
    localparam int CKD_MASK_OPT_W   = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] CKD_SEL_RESET    = 2'h0;
    localparam logic       CKD_ENABLE_RESET = 1'b1;
    localparam logic       CKD_TB_SRC_RESET = 1'b0;

    // ------------------------------------------------------------
    // Divider chain: 7-bit prescaler below a 6-bit delay counter
    // ------------------------------------------------------------
    localparam int          CKD_PRE_W   = 7;
    localparam int          CKD_POD_W   = 6;
    localparam int          CKD_CHAIN_W = CKD_PRE_W + CKD_POD_W;
    localparam logic [12:0] CKD_PRESET  = 13'h0078;

    // System clock select codes
    localparam logic [1:0] CKD_SEL_MAIN_2  = 2'h0;
    localparam logic [1:0] CKD_SEL_MAIN_4  = 2'h1;
    localparam logic [1:0] CKD_SEL_MAIN_64 = 2'h2;
    localparam logic [1:0] CKD_SEL_SUB_2   = 2'h3;

    // Power mode states
    typedef enum logic [1:0] {
        CKD_RUN      = 2'b00,
        CKD_WAIT     = 2'b01,
        CKD_STOP     = 2'b10,
        CKD_RECOVER  = 2'b11
    } ckd_mode_t;

endpackage : ckd_pkg

//--- rtl/ckd_div_if.sv
// Link between the clock controller and its prescaler/delay chain.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface ckd_div_if;
    logic run;        // Main oscillator running
    logic tick;       // One main oscillator cycle
    logic preset;     // Load chain with preset value
    logic clear_pod;  // Clear delay counter only
    logic tap2;
    logic tap4;
    logic tap64;
    logic tap128;
    logic ovf;        // Delay counter overflow

    modport ctl (output run, tick, preset, clear_pod, input tap2, tap4, tap64, tap128, ovf);
    modport div (input run, tick, preset, clear_pod, output tap2, tap4, tap64, tap128, ovf);
endinterface : ckd_div_if
`default_nettype wire

//--- rtl/ckd_prescaler.sv
// Prescaler plus power-on-delay counter driven by main oscillator ticks.
// Assumes ticks arrive as one-cycle pulses synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module ckd_prescaler
    import ckd_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Controller side
    ckd_div_if.div    dv
);

    typedef struct packed {
        logic [CKD_CHAIN_W-1:0] cnt;
    } ckd_pre_state_t;

    ckd_pre_state_t q;
    ckd_pre_state_t d;
    logic           step;

    // ------------------------------------------------------------
    // Taps and overflow
    // ------------------------------------------------------------
    assign step      = dv.run && dv.tick;
    assign dv.tap2   = step && q.cnt[0];                          // RULE_10
    assign dv.tap4   = step && (&q.cnt[1:0]);
    assign dv.tap64  = step && (&q.cnt[5:0]);
    assign dv.tap128 = step && (&q.cnt[CKD_PRE_W-1:0]);
    assign dv.ovf    = step && (&q.cnt) && !dv.preset && !dv.clear_pod; // RULE_11

    // ------------------------------------------------------------
    // Next count
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        if (dv.preset) begin
            d.cnt = CKD_PRESET;                                   // RULE_12
        end else if (dv.clear_pod) begin
            d.cnt[CKD_CHAIN_W-1:CKD_PRE_W] = '0;                  // RULE_02
        end else if (step) begin
            d.cnt = q.cnt + 13'h0001;                             // Wraps at overflow
        end
    end

    // Power-on detection loads the preset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q.cnt <= CKD_PRESET;                                  // RULE_12
        end else begin
            q <= d;
        end
    end

endmodule : ckd_prescaler
`default_nettype wire

//--- rtl/ckd_clock_ctrl.sv
// Dual oscillator clock control: system clock select, stop/wait
// sequencing, start-up delay and its register file on APB.
// Assumes oscillator ticks, wake sources and CPU requests are
// synchronous one-cycle pulses or levels on clk; rst is power-on.
//
// Behaviour
// RULE_01 - Main oscillator halts by stop or enable clear
// RULE_02 - Stop clears delay counter, keeps prescaler
// RULE_03 - Interrupt/reset exit restarts oscillator, waits overflow
// RULE_04 - External reset restores select and enable
// RULE_05 - Sub oscillator always runs, usable as source
// RULE_06 - On sub clock, main oscillator stoppable
// RULE_07 - Sub clock stop exit resumes at once
// RULE_08 - Enable clear presets chain, set restarts
// RULE_09 - Enable cleared: stop exit leaves oscillator off
// RULE_10 - Prescaler taps 2, 4, 64, 128
// RULE_11 - Delay overflow sets stable, releases delay
// RULE_12 - Chain preset on power-on and enable clear
// RULE_13 - System clock feeds all but time base
// RULE_14 - Select code picks system clock ratio
// RULE_15 - Reset selects main divided by two
// RULE_16 - Stop gates everything except time base
// RULE_17 - Stop entry clears stable, inits counter
// RULE_18 - Stop exit sources listed, time base conditional
// RULE_19 - Main clock stop exit waits overflow
// RULE_20 - Sub clock stop exit has no wait
// RULE_21 - Wait halts processor only, any interrupt exits
// RULE_22 - Oscillator option settings readable by software
// RULE_23 - Time base source select, write once
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ckd_clock_ctrl
    import ckd_pkg::*;
(
    // Clock and power-on reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [CKD_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Oscillators
    input  wire logic                  main_osc_tick,
    input  wire logic                  sub_osc_tick,
    output logic                       main_osc_run,
    // Processor requests and reset sources
    input  wire logic                  stop_req,
    input  wire logic                  wait_req,
    input  wire logic                  ext_reset,
    input  wire logic                  int_reset,
    // Wake-up sources
    input  wire logic                  irq1,
    input  wire logic                  irq2,
    input  wire logic                  key_wakeup_interrupt,
    input  wire logic                  spi1_slave_wake,
    input  wire logic                  spi2_slave_wake,
    input  wire logic                  time_base_irq,
    input  wire logic                  any_irq,
    // Mask option straps
    input  wire logic [CKD_MASK_OPT_W-1:0] mask_option,
    // Clock enables and status
    output logic                       sys_clk_en,
    output logic                       cpu_clk_en,
    output logic                       time_base_clk_en,
    output logic                       reset_hold,
    output logic                       main_clk_stable_flag
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ckd_mode_t   mode;
        logic [1:0]  sel;          // sysclk_select_hi, sysclk_select_lo
        logic        main_clk_enable;
        logic        stable;
        logic        tb_src;       // timebase_source_select
        logic        tb_written;
        logic        hold;
        logic        osc_run;
        logic        sub_div;
        logic        sys_en;
        logic        cpu_en;
        logic        tb_en;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
    } ckd_state_t;

    ckd_state_t q;
    ckd_state_t d;

    ckd_div_if  dv ();

    logic       wr_acc;
    logic       setup;
    logic [5:0] idx;
    logic       mapped;
    logic       rst_ev;
    logic       wake;
    logic       main_is_sys;
    logic       sys_pulse;
    logic       sub_pulse;
    logic       wr_enable_val;
    logic       enable_clear;
    logic       stop_enter;

    // ------------------------------------------------------------
    // Prescaler and delay counter
    // ------------------------------------------------------------
    ckd_prescaler u_pre (
        .clk (clk),
        .rst (rst),
        .dv  (dv.div)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Pick the system clock pulse for a select code
    function automatic logic ckd_sel_pulse(input logic [1:0] sel, input logic t2, input logic t4,
                                           input logic t64, input logic s2);
        logic p;
        p = 1'b0;
        case (sel)
            CKD_SEL_MAIN_2:  p = t2;
            CKD_SEL_MAIN_4:  p = t4;
            CKD_SEL_MAIN_64: p = t64;
            CKD_SEL_SUB_2:   p = s2;
            default:         p = 1'b0;
        endcase
        return p;
    endfunction : ckd_sel_pulse

    // Bus decode; access lasts one cycle since ready is raised at setup
    assign setup  = psel && !penable;
    assign idx    = paddr[7:2];
    assign mapped = (paddr[1:0] == 2'h0) &&
                    (idx == CKD_IDX_MISC || idx == CKD_IDX_MASK_OPT || idx == CKD_IDX_TB_CTRL);
    assign wr_acc = psel && penable && q.ready && pwrite && mapped && pstrb[0];

    // Reset sources that restore register defaults
    assign rst_ev = ext_reset || int_reset;

    // Stop wake-up; time base only counts when it runs from the sub oscillator
    assign wake = irq1 || irq2 || key_wakeup_interrupt || spi1_slave_wake ||
                  spi2_slave_wake || (time_base_irq && !q.tb_src);   // RULE_18

    assign main_is_sys = (q.sel != CKD_SEL_SUB_2);
    assign sub_pulse   = sub_osc_tick && q.sub_div;                   // RULE_05
    assign sys_pulse   = ckd_sel_pulse(q.sel, dv.tap2, dv.tap4, dv.tap64, sub_pulse); // RULE_14

    assign wr_enable_val = pwdata[CKD_MISC_ENABLE];
    assign enable_clear  = wr_acc && (idx == CKD_IDX_MISC) && !wr_enable_val && q.main_clk_enable;
    assign stop_enter    = (q.mode == CKD_RUN) && stop_req && !rst_ev;

    // Divider chain control
    assign dv.run       = q.osc_run;
    assign dv.tick      = main_osc_tick;
    assign dv.preset    = enable_clear && !rst_ev;                    // RULE_08
    assign dv.clear_pod = stop_enter && q.main_clk_enable;            // RULE_02

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;

        // Sub oscillator divide by two never stops
        if (sub_osc_tick) begin
            d.sub_div = !q.sub_div;                                   // RULE_05
        end

        // Register writes
        if (wr_acc) begin
            case (idx)
                CKD_IDX_MISC: begin
                    d.sel             = {pwdata[CKD_MISC_SEL_HI], pwdata[CKD_MISC_SEL_LO]};
                    d.main_clk_enable = wr_enable_val;                // RULE_01
                    if (!wr_enable_val) begin
                        d.stable = 1'b0;                              // RULE_08
                    end
                end
                CKD_IDX_TB_CTRL: begin
                    if (!q.tb_written) begin
                        d.tb_src     = pwdata[CKD_TB_SRC_BIT];        // RULE_23
                        d.tb_written = 1'b1;
                    end
                end
                default: begin
                    d.tb_written = q.tb_written;
                end
            endcase
        end

        // Power mode sequencing
        case (q.mode)
            CKD_RUN: begin
                if (stop_req) begin
                    d.mode   = CKD_STOP;                              // RULE_16
                    d.stable = 1'b0;                                  // RULE_17
                end else if (wait_req) begin
                    d.mode = CKD_WAIT;                                // RULE_21
                end
            end
            CKD_WAIT: begin
                if (any_irq) begin
                    d.mode = CKD_RUN;                                 // RULE_21
                end
            end
            CKD_STOP: begin
                if (wake) begin
                    if (main_is_sys) begin
                        d.mode = CKD_RECOVER;                         // RULE_03 RULE_19
                    end else begin
                        d.mode = CKD_RUN;                             // RULE_07 RULE_09 RULE_20
                    end
                end
            end
            CKD_RECOVER: begin
                if (dv.ovf) begin
                    d.mode = CKD_RUN;                                 // RULE_11 RULE_19
                    d.hold = 1'b0;                                    // RULE_03
                end
            end
            default: begin
                d.mode = CKD_RUN;
            end
        endcase

        // External or internal reset restores defaults
        if (rst_ev) begin
            d.sel             = CKD_SEL_RESET;                        // RULE_04 RULE_15
            d.main_clk_enable = CKD_ENABLE_RESET;                     // RULE_04
            d.tb_src          = CKD_TB_SRC_RESET;                     // RULE_23
            d.tb_written      = 1'b0;
            // Oscillator was off or still starting: hold until overflow
            if (q.mode == CKD_STOP || q.mode == CKD_RECOVER || !q.main_clk_enable) begin
                d.mode = CKD_RECOVER;                                 // RULE_03
                d.hold = 1'b1;
            end else begin
                d.mode = CKD_RUN;
                d.hold = 1'b0;
            end
        end

        // Overflow sets the stable flag; ovf is masked by preset and clear_pod, so clears made with those win
        if (dv.ovf) begin
            d.stable = 1'b1;                                          // RULE_11 RULE_07
        end

        // Oscillator runs only when enabled and not stopped
        d.osc_run = d.main_clk_enable && (d.mode != CKD_STOP);        // RULE_01 RULE_06 RULE_08

        // Clock enables; stop gates the system path off
        d.sys_en = sys_pulse && (q.mode == CKD_RUN || q.mode == CKD_WAIT); // RULE_13 RULE_16
        d.cpu_en = sys_pulse && (q.mode == CKD_RUN) && !q.hold;           // RULE_21
        d.tb_en  = q.tb_src ? dv.tap128 : sub_osc_tick;                    // RULE_13 RULE_23

        // Bus answer, one cycle after setup
        d.ready = setup;
        d.err   = setup && !mapped;
        d.rdata = 32'h0000_0000;
        if (setup && !pwrite && mapped) begin
            case (idx)
                CKD_IDX_MISC: begin
                    d.rdata[CKD_MISC_STABLE] = q.stable;
                    d.rdata[CKD_MISC_SEL_HI] = q.sel[1];
                    d.rdata[CKD_MISC_SEL_LO] = q.sel[0];
                    d.rdata[CKD_MISC_ENABLE] = q.main_clk_enable;
                end
                CKD_IDX_MASK_OPT: begin
                    d.rdata[CKD_MASK_OPT_W-1:0] = mask_option;        // RULE_22
                end
                CKD_IDX_TB_CTRL: begin
                    d.rdata[CKD_TB_SRC_BIT] = q.tb_src;
                end
                default: begin
                    d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers; power-on starts in recovery with reset held
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q.mode            <= CKD_RECOVER;
            q.sel             <= CKD_SEL_RESET;                       // RULE_15
            q.main_clk_enable <= CKD_ENABLE_RESET;
            q.stable          <= 1'b0;
            q.tb_src          <= CKD_TB_SRC_RESET;
            q.tb_written      <= 1'b0;
            q.hold            <= 1'b1;
            q.osc_run         <= 1'b1;
            q.sub_div         <= 1'b0;
            q.sys_en          <= 1'b0;
            q.cpu_en          <= 1'b0;
            q.tb_en           <= 1'b0;
            q.rdata           <= 32'h0000_0000;
            q.ready           <= 1'b0;
            q.err             <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    assign prdata               = q.rdata;
    assign pready               = q.ready;
    assign pslverr              = q.err;
    assign main_osc_run         = q.osc_run;
    assign sys_clk_en           = q.sys_en;
    assign cpu_clk_en           = q.cpu_en;
    assign time_base_clk_en     = q.tb_en;
    assign reset_hold           = q.hold;
    assign main_clk_stable_flag = q.stable;

endmodule : ckd_clock_ctrl
`default_nettype wire

//--- tb/ckd_clock_ctrl_properties.sv
// Port checks of the clock controller.
// Assumes a bind into ckd_clock_ctrl.
`timescale 1ns/100ps
`default_nettype none
module ckd_clock_ctrl_properties
    import ckd_pkg::*;
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // Register bus
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [CKD_ADDR_W-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Oscillator and status
    input wire logic                  main_osc_run,
    input wire logic                  cpu_clk_en,
    input wire logic                  reset_hold,
    input wire logic                  main_clk_stable_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Write access to the misc register
    logic misc_wr;
    assign misc_wr = psel && penable && pready && pwrite && pstrb[0] && (paddr == {CKD_IDX_MISC, 2'b00});

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // Zero wait states
    AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("no answer");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("long answer");
    AST_NO_STRAY_READY: assert property (!psel |=> !pready)
        else $error("stray answer");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("stray error");
    AST_UNMAPPED_ERR: assert property (psel && !penable && !(paddr inside {8'hf0, 8'hf4, 8'hf8}) |=> pslverr)
        else $error("not refused");

    // ------------------------------------------------------------
    // Oscillator and start-up
    // ------------------------------------------------------------
    // Stopped means not stable
    AST_STABLE_NEEDS_OSC: assert property (!main_osc_run |-> !main_clk_stable_flag)
        else $error("stable while off");
    AST_HOLD_ENDS_STABLE: assert property ($fell(reset_hold) |-> main_clk_stable_flag)
        else $error("early release");
    AST_CPU_HELD: assert property (reset_hold && $past(reset_hold) |-> !cpu_clk_en)
        else $error("cpu clocked in hold");
    AST_EN_CLEAR_STOPS: assert property (misc_wr && !pwdata[1] |-> ##[1:2] !main_osc_run)
        else $error("no stop");
    AST_EN_SET_RUNS: assert property (misc_wr && pwdata[1] |-> ##[1:2] main_osc_run)
        else $error("no start");

    // Main scenarios reached
    COV_STOP: cover property ($fell(main_osc_run));
    COV_STABLE: cover property ($rose(main_clk_stable_flag));
    COV_REFUSED: cover property (pslverr);
endmodule : ckd_clock_ctrl_properties
`default_nettype wire

//--- tb/ckd_clock_ctrl_tb.sv
// Self-checking bench for the clock controller.
// Assumes the package, design and checker compile first.
`timescale 1ns/100ps
`default_nettype none
module ckd_clock_ctrl_tb
    import ckd_pkg::*;
;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        main_osc_tick, sub_osc_tick, main_osc_run;
    logic [6:0]  ev;
    logic [2:0]  mask_option;
    logic        sys_clk_en, cpu_clk_en, time_base_clk_en, reset_hold, main_clk_stable_flag;
    logic [33:0] exq[$];
    logic [33:0] e;
    int          n_mismatch, tests_run, c_sys, c_cpu, c_tb, tk, b;

    // ev: stop, wait, irq1, irq2, key, any irq, ext reset
    ckd_clock_ctrl u_dut (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .main_osc_tick, .sub_osc_tick, .main_osc_run, .stop_req(ev[0]), .wait_req(ev[1]),
        .ext_reset(ev[6]), .int_reset(1'b0), .irq1(ev[2]), .irq2(ev[3]), .key_wakeup_interrupt(ev[4]),
        .spi1_slave_wake(1'b0), .spi2_slave_wake(1'b0), .time_base_irq(1'b0), .any_irq(ev[5]),
        .mask_option, .sys_clk_en, .cpu_clk_en, .time_base_clk_en, .reset_hold, .main_clk_stable_flag
    );

    // ------------------------------------------------------------
    // Clock, oscillator ticks, answer monitor
    // ------------------------------------------------------------
    initial clk = 1'b0;
    always #50 clk = ~clk;

    // Main tick every other cycle; tk counts ticks while running
    always @(posedge clk) begin
        main_osc_tick <= ~main_osc_tick;
        sub_osc_tick  <= ($urandom % 4) == 0;
        if (!rst && main_osc_tick && main_osc_run) tk <= tk + 1;
    end

    // Oldest bus note per answer
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            if (exq.size() == 0) begin
                chk(1'b0, "stray answer");
            end else begin
                e = exq.pop_front();
                chk(pslverr === e[32] && (!e[33] || prdata === e[31:0]), "bus answer");
            end
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input bit ok, input string m);
        tests_run++;
        if (!ok) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk

    // Setup, then access until answer
    task apb(input bit wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
             input logic [31:0] x, input bit err);
        int n;
        n = 0;
        exq.push_back({~wr, err, x});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(n < 20, "no answer");
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf, 32'h0, 1'b0);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, 4'hf, x, 1'b0);
    endtask : rd

    task pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
        @(posedge clk);
    endtask : pulse

    // Count enable pulses
    task watch(input int n);
        {c_sys, c_cpu, c_tb} = '0;
        repeat (n) begin
            @(posedge clk);
            if (sys_clk_en === 1'b1) c_sys++;
            if (cpu_clk_en === 1'b1) c_cpu++;
            if (time_base_clk_en === 1'b1) c_tb++;
        end
    endtask : watch

    // Ticks since base b until stable; a hang ends at the watchdog
    task ticks(input int b, input int lo, input int hi);
        wait (main_clk_stable_flag === 1'b1);
        @(negedge clk);
        chk(tk - b >= lo && tk - b <= hi, "start-up ticks");
    endtask : ticks

    task test_done();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // Four start-ups plus margin
    initial begin
        #(100 * 90000);
        n_mismatch++;
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, ev, main_osc_tick, sub_osc_tick, tk} = '0;
        pstrb = 4'hf;
        n_mismatch = 0;
        tests_run = 0;
        void'($urandom(32'h79b20817));
        mask_option = 3'($urandom);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        ticks(0, 8072, 8074);
        watch(4);
        chk(reset_hold === 1'b0 && main_osc_run === 1'b1, "hold after start-up");
        rd(8'hf8, 32'h82);
        rd(8'hf4, {29'h0, mask_option});
        apb(1'b0, 8'hfc, 32'h0, 4'hf, 32'h0, 1'b1);
        apb(1'b0, 8'hf9, 32'h0, 4'hf, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(8'hf8, 32'(i * 4 + 2));
            rd(8'hf8, 32'(8'h82 + i * 4));
        end
        apb(1'b1, 8'hf8, 32'h0, 4'he, 32'h0, 1'b0);
        rd(8'hf8, 32'h8e);
        // Stop on sub clock, enable set
        pulse(0);
        watch(40);
        chk(main_osc_run === 1'b0 && main_clk_stable_flag === 1'b0, "stop entry");
        chk(c_sys == 0 && c_tb > 0, "stop gating");
        b = tk;
        pulse(4);
        watch(40);
        chk(main_osc_run === 1'b1 && c_sys > 0, "sub wake");
        ticks(b, 8064, 8194);
        // Enable cleared, stop, wake, enable set
        wr(8'hf8, 32'h0c);
        watch(4);
        chk(main_osc_run === 1'b0 && main_clk_stable_flag === 1'b0, "enable clear");
        pulse(0);
        pulse(2);
        watch(40);
        chk(main_osc_run === 1'b0 && c_sys > 0, "wake, enable off");
        b = tk;
        wr(8'hf8, 32'h0e);
        ticks(b, 8072, 8074);
        // Stop on main clock
        wr(8'hf8, 32'h02);
        pulse(0);
        b = tk;
        pulse(3);
        watch(20);
        chk(main_osc_run === 1'b1 && c_cpu == 0 && c_sys == 0, "recovery");
        ticks(b, 8064, 8194);
        watch(20);
        chk(c_cpu > 0, "resume");
        // Wait mode
        pulse(1);
        watch(20);
        chk(c_cpu == 0 && c_sys > 0, "wait mode");
        pulse(5);
        watch(20);
        chk(c_cpu > 0, "wait exit");
        wr(8'hf0, ($urandom & 32'hffffff00) | 32'h80);
        wr(8'hf0, 32'h0);
        rd(8'hf0, 32'h80);
        wr(8'hf8, 32'h0a);
        pulse(6);
        chk(reset_hold === 1'b0, "no wait on reset");
        rd(8'hf8, 32'h82);
        rd(8'hf0, 32'h0);
        test_done();
    end
endmodule : ckd_clock_ctrl_tb

bind ckd_clock_ctrl ckd_clock_ctrl_properties u_props (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
    .main_osc_run, .cpu_clk_en, .reset_hold, .main_clk_stable_flag
);
`default_nettype wire
